// [core/fcoc_defs.svh]
/*
  register offsets, field positions, reset values and timing constants
  of the flash clock and option control block.
  assumes byte addressing on a 32-bit avalon-mm slave port.
*/
`ifndef FCOC_DEFS_SVH
`define FCOC_DEFS_SVH

`define FCOC_OFS_CLKDIV 4'h0
`define FCOC_OFS_OPTIONS 4'h4
`define FCOC_OFS_KEY 4'h8
`define FCOC_OFS_STATUS 4'hc

`define FCOC_LOADED_BIT 7
`define FCOC_PRESCALE_BIT 6
`define FCOC_BACKDOOR_KEY_ENABLE_BIT 7
`define FCOC_NORED_BIT 6

`define FCOC_SEC_UNSECURED 2'h2
`define FCOC_PRESCALE_MAX 3'h7
`define FCOC_PRESCALE_SHIFT 4'h3
`define FCOC_KEY_LAST 3'h7
`define FCOC_RESET_WORD 32'h0

`endif

// [core/fcoc_pkg.sv]
/*
  types of the flash clock and option control block.
  assumes nothing beyond a systemverilog compiler.
*/
package fcoc_pkg;

  typedef enum logic {FCOC_IDLE, FCOC_RUN} fcoc_op_state_t;

  typedef struct packed {
    logic [2:0] pre;
    logic [5:0] cnt;
    logic tick;
  } fcoc_div_st_t;

  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic loaded;
    logic prescale;
    logic [5:0] divisor;
    logic [7:0] options;
    logic [1:0] sec;
    logic [2:0] key_idx;
    logic key_ok;
    fcoc_op_state_t op;
    logic [7:0] op_left;
    logic op_done;
  } fcoc_st_t;

endpackage

// [core/fcoc_clk_div.sv]
/*
  prescaler and divider that make the internal flash clock as a
  one-cycle enable on clk_sys.
  assumes its settings hold still while enable is high.
*/
`include "fcoc_defs.svh"

module fcoc_clk_div
  import fcoc_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // settings
  input wire logic enable,
  input wire logic prescale_by_eight,
  input wire logic [5:0] divisor,
  // flash clock enable
  output logic tick
);
  import fcoc_pkg::*;

  fcoc_div_st_t st_q;
  fcoc_div_st_t st_d;
  logic pre_tick;

  always_comb
  begin
    st_d = st_q;
    st_d.tick = 1'b0;
    pre_tick = !prescale_by_eight || st_q.pre == `FCOC_PRESCALE_MAX;
    if (rst || !enable)
    begin
      st_d = '0;
    end
    else
    begin
      st_d.pre = st_q.pre + 3'h1;
      if (pre_tick)
      begin
        if (st_q.cnt == divisor)
        begin
          st_d.cnt = 6'h0;
          st_d.tick = 1'b1;
        end
        else
        begin
          st_d.cnt = st_q.cnt + 6'h1;
        end
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    st_q <= st_d;
  end

  assign tick = st_q.tick;

  // cycles since the previous tick, for the period check
  logic [9:0] gap_q;
  logic seen_q;
  logic [9:0] period_exp;

  assign period_exp = ({4'h0, divisor} + 10'h1)
    << (prescale_by_eight ? `FCOC_PRESCALE_SHIFT : 4'h0);

  always_ff @(posedge clk_sys)
  begin
    if (rst || !enable)
    begin
      gap_q <= 10'h0;
      seen_q <= 1'b0;
    end
    else if (st_q.tick)
    begin
      gap_q <= 10'h0;
      seen_q <= 1'b1;
    end
    else
    begin
      gap_q <= gap_q + 10'h1;
    end
  end

  property p_internal_flash_clock_period;
    @(posedge clk_sys) disable iff (rst)
      (enable && seen_q && st_q.tick) |-> gap_q + 10'h1 == period_exp;
  endproperty
  a_internal_flash_clock_period: assert property (p_internal_flash_clock_period)
    else $error("flash clock period wrong");

  property p_no_tick_off;
    @(posedge clk_sys) disable iff (rst)
      !enable |=> !st_q.tick;
  endproperty
  a_no_tick_off: assert property (p_no_tick_off)
    else $error("flash clock runs while not loaded");

endmodule

// [core/fcoc_top.sv]
/*
  flash clock and option control: write-once clock divider register,
  options loaded from the stored options byte at reset, backdoor key
  check, security state and flash operation gating.
  assumes an avalon-mm master on clk_sys and a flash array that gives
  the stored bytes as steady levels on clk_sys.
*/
// Local design decisions: the Avalon-MM interface to the registers and the placing of the registers.
`include "fcoc_defs.svh"

// Function
// - the loaded flag clears on reset, sets on the first divider write and is read-only.
// - erase and program operations are refused until the loaded flag is set.
// - prescale and divisor bits read any time and take only the first write.
// - prescale 0 feeds the bus clock to the divider, 1 feeds it divided by 8.
// - the flash clock is the prescaler output divided by divisor plus one.
// - each timing pulse is one flash clock cycle and operations use whole pulses.
// - every reset copies the stored options byte into the options register.
// - with key enable set, eight matching key bytes unsecure until reset.
// - key bytes written from the background debug interface are ignored.
// - the redirection disable bit turns vector redirection off.
// - the security field sets the state and secure blocks unsecured access.
// - a good key entry or blank check sets the unsecured code.
module fcoc_top
  import fcoc_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // avalon-mm slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // source of the current bus access
  input wire logic bus_from_debug,
  // stored flash contents
  input wire logic [7:0] stored_options_byte,
  input wire logic [63:0] stored_backdoor_key,
  // flash operation control
  input wire logic flash_op_req,
  input wire logic [7:0] flash_op_pulses,
  input wire logic blank_check_ok,
  output logic flash_op_accept,
  output logic flash_op_busy,
  output logic flash_op_done,
  output logic flash_timing_pulse,
  // option and security state
  output logic divisor_loaded_flag,
  output logic backdoor_key_enable,
  output logic redirection_disable,
  output logic [1:0] security_state_field,
  output logic mem_access_block
);
  import fcoc_pkg::*;

  fcoc_st_t st_q;
  fcoc_st_t st_d;
  logic internal_flash_clock_tick;
  logic wr_go;
  logic clkdiv_wr;
  logic key_wr;
  logic key_wr_dbg;
  logic key_byte_ok;
  logic key_last_good;
  logic secure;

  fcoc_clk_div fcoc_clk_div_i (
    .clk_sys(clk_sys),
    .rst(rst),
    .enable(st_q.loaded),
    .prescale_by_eight(st_q.prescale),
    .divisor(st_q.divisor),
    .tick(internal_flash_clock_tick)
  );

  // a write takes effect in the cycle waitrequest is low
  assign wr_go = avs_write && st_q.ack && avs_byteenable[0];
  assign clkdiv_wr = wr_go && avs_address == `FCOC_OFS_CLKDIV;
  assign key_wr = wr_go && avs_address == `FCOC_OFS_KEY && !bus_from_debug
    && st_q.options[`FCOC_BACKDOOR_KEY_ENABLE_BIT] && secure;
  assign key_wr_dbg = wr_go && avs_address == `FCOC_OFS_KEY
    && bus_from_debug;
  assign key_byte_ok = avs_writedata[7:0]
    == stored_backdoor_key[{st_q.key_idx, 3'h0} +: 8];
  assign key_last_good = key_wr && st_q.key_idx == `FCOC_KEY_LAST
    && key_byte_ok && (st_q.key_ok || st_q.key_idx == 3'h0);
  assign secure = st_q.sec != `FCOC_SEC_UNSECURED;

  always_comb
  begin
    st_d = st_q;
    st_d.ack = (avs_read || avs_write) && !st_q.ack;
    st_d.op_done = 1'b0;
    if (avs_read && !st_q.ack)
    begin
      if (avs_address == `FCOC_OFS_CLKDIV)
      begin
        st_d.rdata = {24'h0, st_q.loaded, st_q.prescale, st_q.divisor};
      end
      else if (avs_address == `FCOC_OFS_OPTIONS)
      begin
        st_d.rdata = {24'h0, st_q.options[7:2], st_q.sec};
      end
      else if (avs_address == `FCOC_OFS_STATUS)
      begin
        st_d.rdata = {27'h0, st_q.key_idx, secure, st_q.op == FCOC_RUN};
      end
      else
      begin
        st_d.rdata = `FCOC_RESET_WORD;
      end
    end
    // only the first write lands; the flag ignores the data
    if (clkdiv_wr && !st_q.loaded)
    begin
      st_d.loaded = 1'b1;
      st_d.prescale = avs_writedata[`FCOC_PRESCALE_BIT];
      st_d.divisor = avs_writedata[5:0];
    end
    // options register has no write path
    if (key_wr)
    begin
      st_d.key_idx = st_q.key_idx + 3'h1;
      st_d.key_ok = key_byte_ok && (st_q.key_ok || st_q.key_idx == 3'h0);
      if (key_last_good)
      begin
        st_d.sec = `FCOC_SEC_UNSECURED;
      end
    end
    if (blank_check_ok)
    begin
      st_d.sec = `FCOC_SEC_UNSECURED;
    end
    case (st_q.op)
      FCOC_IDLE:
      begin
        if (flash_op_accept)
        begin
          st_d.op = FCOC_RUN;
          st_d.op_left = flash_op_pulses;
        end
      end
      FCOC_RUN:
      begin
        if (internal_flash_clock_tick)
        begin
          st_d.op_left = st_q.op_left - 8'h1;
          if (st_q.op_left <= 8'h1)
          begin
            st_d.op = FCOC_IDLE;
            st_d.op_done = 1'b1;
          end
        end
      end
      default:
      begin
        st_d.op = FCOC_IDLE;
      end
    endcase
    if (rst)
    begin
      st_d = '0;
      st_d.op = FCOC_IDLE;
      st_d.options = stored_options_byte;
      st_d.sec = stored_options_byte[1:0];
    end
  end

  always_ff @(posedge clk_sys)
  begin
    st_q <= st_d;
  end

  assign avs_waitrequest = (avs_read || avs_write) && !st_q.ack;
  assign avs_readdata = st_q.rdata;
  assign flash_op_accept = flash_op_req && st_q.loaded
    && st_q.op == FCOC_IDLE;
  assign flash_op_busy = st_q.op == FCOC_RUN;
  assign flash_op_done = st_q.op_done;
  assign flash_timing_pulse = internal_flash_clock_tick && st_q.op == FCOC_RUN;
  assign divisor_loaded_flag = st_q.loaded;
  assign backdoor_key_enable = st_q.options[`FCOC_BACKDOOR_KEY_ENABLE_BIT];
  assign redirection_disable = st_q.options[`FCOC_NORED_BIT];
  assign security_state_field = st_q.sec;
  assign mem_access_block = secure;

  sequence s_clkdiv_write;
    clkdiv_wr;
  endsequence

  sequence s_reset_release;
    $fell(rst);
  endsequence

  property p_loaded_on_write;
    @(posedge clk_sys) disable iff (rst)
      s_clkdiv_write |=> st_q.loaded ##1 st_q.loaded;
  endproperty
  a_loaded_on_write: assert property (p_loaded_on_write)
    else $error("loaded flag not set by divider write");

  property p_write_once;
    @(posedge clk_sys) disable iff (rst)
      st_q.loaded |=> $stable({st_q.prescale, st_q.divisor}) && st_q.loaded;
  endproperty
  a_write_once: assert property (p_write_once)
    else $error("divider settings changed after first write");

  property p_refuse_unloaded;
    @(posedge clk_sys) disable iff (rst)
      (flash_op_req && !st_q.loaded && st_q.op == FCOC_IDLE)
        |-> !flash_op_accept ##1 !flash_op_busy;
  endproperty
  a_refuse_unloaded: assert property (p_refuse_unloaded)
    else $error("flash operation started before divider loaded");

  property p_op_start;
    @(posedge clk_sys) disable iff (rst)
      (flash_op_req && st_q.loaded && st_q.op == FCOC_IDLE)
        |=> flash_op_busy;
  endproperty
  a_op_start: assert property (p_op_start)
    else $error("allowed flash operation not started");

  property p_options_load;
    @(posedge clk_sys)
      s_reset_release |-> st_q.options == $past(stored_options_byte)
        && redirection_disable == $past(stored_options_byte[6]);
  endproperty
  a_options_load: assert property (p_options_load)
    else $error("options not copied at reset");

  property p_options_fixed;
    @(posedge clk_sys) disable iff (rst)
      1'b1 |=> $stable(st_q.options);
  endproperty
  a_options_fixed: assert property (p_options_fixed)
    else $error("options register changed outside reset");

  property p_key_disabled;
    @(posedge clk_sys) disable iff (rst)
      (!backdoor_key_enable && !blank_check_ok) |=> $stable(st_q.sec);
  endproperty
  a_key_disabled: assert property (p_key_disabled)
    else $error("security changed with key mechanism off");

  property p_key_unlock;
    @(posedge clk_sys) disable iff (rst)
      key_last_good |=> !mem_access_block;
  endproperty
  a_key_unlock: assert property (p_key_unlock)
    else $error("good key did not unsecure");

  property p_debug_key;
    @(posedge clk_sys) disable iff (rst)
      key_wr_dbg |=> $stable(st_q.key_idx) && $stable(st_q.sec);
  endproperty
  a_debug_key: assert property (p_debug_key)
    else $error("debug key write took effect");

  property p_secure_holds;
    @(posedge clk_sys) disable iff (rst)
      (mem_access_block && !blank_check_ok && !key_last_good)
        |=> mem_access_block;
  endproperty
  a_secure_holds: assert property (p_secure_holds)
    else $error("security dropped without cause");

  property p_blank_unsec;
    @(posedge clk_sys) disable iff (rst)
      blank_check_ok |=> security_state_field == `FCOC_SEC_UNSECURED;
  endproperty
  a_blank_unsec: assert property (p_blank_unsec)
    else $error("blank check did not unsecure");

  property p_pulse_in_run;
    @(posedge clk_sys) disable iff (rst)
      flash_timing_pulse |-> flash_op_busy && internal_flash_clock_tick;
  endproperty
  a_pulse_in_run: assert property (p_pulse_in_run)
    else $error("timing pulse outside operation");

  property p_done_after_pulse;
    @(posedge clk_sys) disable iff (rst)
      flash_op_done |-> $past(flash_timing_pulse) && !flash_op_busy;
  endproperty
  a_done_after_pulse: assert property (p_done_after_pulse)
    else $error("operation ended without a final pulse");

  property p_busy_until_done;
    @(posedge clk_sys) disable iff (rst)
      (flash_op_busy && !flash_timing_pulse) |=> flash_op_busy;
  endproperty
  a_busy_until_done: assert property (p_busy_until_done)
    else $error("operation ended between timing pulses");

  property p_idle_unloaded;
    @(posedge clk_sys) disable iff (rst)
      !divisor_loaded_flag |-> !flash_op_busy && !flash_timing_pulse;
  endproperty
  a_idle_unloaded: assert property (p_idle_unloaded)
    else $error("flash activity before divider loaded");

endmodule

// [testbench/fcoc_top_tb_top.sv]
/*
  self-checking bench of the flash clock and option control block.
  assumes fcoc_pkg is compiled first and fcoc_defs.svh is on the path.
*/
`include "fcoc_defs.svh"

module fcoc_top_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import fcoc_pkg::*;

  logic clk_sys, rst, avs_read, avs_write, avs_waitrequest;
  logic [3:0] avs_address, avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata;
  logic bus_from_debug, flash_op_req, blank_check_ok;
  logic [7:0] stored_options_byte, flash_op_pulses, opt;
  logic [63:0] stored_backdoor_key;
  logic flash_op_accept, flash_op_busy, flash_op_done, flash_timing_pulse;
  logic divisor_loaded_flag, backdoor_key_enable, redirection_disable;
  logic [1:0] security_state_field;
  logic mem_access_block;
  logic [31:0] exp_q[$];
  int mismatches, checks;
  integer seed;

  fcoc_top fcoc_top_i (.clk_sys(clk_sys), .rst(rst),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .bus_from_debug(bus_from_debug),
    .stored_options_byte(stored_options_byte),
    .stored_backdoor_key(stored_backdoor_key),
    .flash_op_req(flash_op_req), .flash_op_pulses(flash_op_pulses),
    .blank_check_ok(blank_check_ok), .flash_op_accept(flash_op_accept),
    .flash_op_busy(flash_op_busy), .flash_op_done(flash_op_done),
    .flash_timing_pulse(flash_timing_pulse),
    .divisor_loaded_flag(divisor_loaded_flag),
    .backdoor_key_enable(backdoor_key_enable),
    .redirection_disable(redirection_disable),
    .security_state_field(security_state_field),
    .mem_access_block(mem_access_block));

  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task give_verdict;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // register read data
  task chk_rd(input logic [31:0] g, input logic [31:0] e);
    chk(g, e);
  endtask

  // operation counts and state
  task chk_op(input logic [31:0] g, input logic [31:0] e);
    chk(g, e);
  endtask

  task limit(input int n, input int lim);
    if (n >= lim)
    begin
      mismatches++;
      give_verdict();
    end
  endtask

  // read data is compared by the monitor when the read completes
  always @(posedge clk_sys)
    if (avs_read && avs_waitrequest === 1'b0)
    begin
      if (exp_q.size() == 0)
        chk_rd(avs_readdata, 32'hdead);
      else
        chk_rd(avs_readdata, exp_q.pop_front());
    end

  task bus(input logic w, input logic [3:0] a, input logic [7:0] d,
           input logic [31:0] e);
    int n;
    @(posedge clk_sys);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= {24'h0, d};
    if (!w)
      exp_q.push_back(e);
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    limit(n, 50);
  endtask

  task do_reset(input logic [7:0] o);
    @(posedge clk_sys);
    rst <= 1'b1;
    stored_options_byte <= o;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
  endtask

  // state flags, two edges after the cause so updates have landed
  task flags(input logic [4:0] e);
    repeat (2) @(posedge clk_sys);
    chk({divisor_loaded_flag, backdoor_key_enable, redirection_disable,
         security_state_field}, e);
  endtask

  task key;
    for (int i = 0; i < 8; i++)
      bus(1'b1, 4'h8, stored_backdoor_key[8*i+:8], 32'h0);
  endtask

  task op(input logic [7:0] p, input int per);
    int n, c, last, gap;
    @(posedge clk_sys);
    flash_op_req <= 1'b1;
    flash_op_pulses <= p;
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
    end while (flash_op_accept !== 1'b1 && n < 50);
    flash_op_req <= 1'b0;
    limit(n, 50);
    c = 0;
    last = 0;
    gap = 0;
    n = 0;
    while (flash_op_done !== 1'b1 && n < 5000)
    begin
      @(posedge clk_sys);
      n++;
      if (n == 1)
        chk_op(flash_op_busy, 1'b1);
      if (flash_timing_pulse === 1'b1)
      begin
        if (c > 0)
          gap = n - last;
        last = n;
        c++;
      end
    end
    limit(n, 5000);
    chk_op(c, p);
    chk_op(gap, per);
  endtask

  initial
  begin
    seed = 32'hdd7c;
    rst = 1'b1;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'h1;
    bus_from_debug = 1'b0;
    flash_op_req = 1'b0;
    flash_op_pulses = 8'h0;
    blank_check_ok = 1'b0;
    stored_backdoor_key = {$random(seed), $random(seed)};
    opt = {2'b10, 4'($random(seed)), 2'b00};
    stored_options_byte = 8'h0;
    do_reset(opt);
    flags({1'b0, opt[7:6], opt[1:0]});
    chk(mem_access_block, 1'b1);
    bus(1'b0, 4'h0, 8'h0, 32'h0);
    bus(1'b0, 4'h4, 8'h0, {24'h0, opt});
    // operation refused while the divider is not loaded
    flash_op_pulses <= 8'h2;
    flash_op_req <= 1'b1;
    repeat (3) @(posedge clk_sys);
    chk({flash_op_accept, flash_op_busy}, 2'b00);
    flash_op_req <= 1'b0;
    bus(1'b1, 4'h4, 8'hff, 32'h0);
    bus(1'b0, 4'h4, 8'h0, {24'h0, opt});
    bus(1'b1, 4'h2, 8'h5a, 32'h0);
    bus(1'b0, 4'h2, 8'h0, 32'h0);
    bus(1'b1, 4'h0, 8'h02, 32'h0);
    bus(1'b0, 4'h0, 8'h0, 32'h82);
    bus(1'b1, 4'h0, 8'h3f, 32'h0);
    bus(1'b0, 4'h0, 8'h0, 32'h82);
    // no operation at this rate; the divider check watches prescale 0
    bus_from_debug <= 1'b1;
    key();
    flags({1'b1, opt[7:6], opt[1:0]});
    bus_from_debug <= 1'b0;
    key();
    flags({1'b1, opt[7:6], 2'h2});
    chk(mem_access_block, 1'b0);
    bus(1'b0, 4'hc, 8'h0, 32'h0);
    // second reset: key disabled, redirection off, secure
    opt = {2'b01, 4'($random(seed)), 2'b11};
    do_reset(opt);
    flags({1'b0, opt[7:6], opt[1:0]});
    key();
    flags({1'b0, opt[7:6], opt[1:0]});
    blank_check_ok <= 1'b1;
    @(posedge clk_sys);
    blank_check_ok <= 1'b0;
    flags({1'b0, opt[7:6], 2'h2});
    // 100 MHz over 8 * 63 gives a flash clock near 198 kHz
    bus(1'b1, 4'h0, 8'h7e, 32'h0);
    bus(1'b0, 4'h0, 8'h0, 32'hfe);
    op(8'h4, 504);
    op(8'h3, 504);
    repeat (3) @(posedge clk_sys);
    chk(exp_q.size(), 0);
    give_verdict();
  end
endmodule
